// *** verilog/slls_pkg.sv ***
// Package of constants and types for the serial lane link status block
package slls_pkg;

    // ****************************************************
    // Bus geometry
    // ****************************************************
    localparam int SLLS_ADDR_W = 14;
    localparam int SLLS_DATA_W = 32;
    localparam int SLLS_IDX_W = 12;

    // ****************************************************
    // Link paging
    // ****************************************************
    localparam int SLLS_NUM_LINKS = 2;
    localparam int SLLS_SEL_W = 1;

    // ****************************************************
    // Register indices; byte address is four times the index
    // ****************************************************
    localparam logic [SLLS_IDX_W-1:0] SLLS_IDX_LINK_PAGE = 12'h300;
    localparam logic [SLLS_IDX_W-1:0] SLLS_IDX_THRESHOLD = 12'h3f0;
    localparam logic [SLLS_IDX_W-1:0] SLLS_IDX_LANE2 = 12'h4b2;
    localparam logic [SLLS_IDX_W-1:0] SLLS_IDX_LANE3 = 12'h4b3;

    localparam logic [SLLS_ADDR_W-1:0] SLLS_ADDR_LINK_PAGE = {SLLS_IDX_LINK_PAGE, 2'b00};
    localparam logic [SLLS_ADDR_W-1:0] SLLS_ADDR_THRESHOLD = {SLLS_IDX_THRESHOLD, 2'b00};
    localparam logic [SLLS_ADDR_W-1:0] SLLS_ADDR_LANE2 = {SLLS_IDX_LANE2, 2'b00};
    localparam logic [SLLS_ADDR_W-1:0] SLLS_ADDR_LANE3 = {SLLS_IDX_LANE3, 2'b00};

    // ****************************************************
    // Status byte field positions
    // ****************************************************
    localparam int SLLS_BIT_DISPARITY = 7;
    localparam int SLLS_BIT_INVALID_CODE = 6;
    localparam int SLLS_BIT_STRAY_K = 5;
    localparam int SLLS_BIT_DESKEW = 4;
    localparam int SLLS_BIT_INIT_ALIGN = 3;
    localparam int SLLS_BIT_CONFIG_SUM = 2;
    localparam int SLLS_BIT_FRAME = 1;
    localparam int SLLS_BIT_CODEGROUP = 0;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [7:0] SLLS_HEALTH_RESET = 8'h00;
    localparam logic [7:0] SLLS_THRESHOLD_RESET = 8'hff;
    localparam logic [SLLS_SEL_W-1:0] SLLS_SEL_RESET = 1'h0;

    // ****************************************************
    // Avalon response codes
    // ****************************************************
    localparam logic [1:0] SLLS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SLLS_RESP_DECODEERROR = 2'h3;

    typedef enum logic [1:0] {
        SLLS_IDLE = 2'b01,
        SLLS_ACK = 2'b10
    } slls_bus_state_type;

endpackage : slls_pkg

// *** verilog/slls_lane_health.sv ***
// One lane's status byte, rebuilt every cycle from the selected link
module slls_lane_health
    import slls_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] threshold,
    input wire logic [7:0] disparity_err_count,
    input wire logic [7:0] invalid_code_count,
    input wire logic [7:0] stray_control_char_count,
    input wire logic deskew_ok,
    input wire logic init_align_ok,
    input wire logic config_sum_ok,
    input wire logic frame_lock,
    input wire logic codegroup_lock,
    output logic [7:0] health
);

    timeunit 1ns;
    timeprecision 1ps;

    // Registered so the bus sees one consistent snapshot per cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            health <= SLLS_HEALTH_RESET; // [R10]
        end else begin
            health[SLLS_BIT_DISPARITY] <= (disparity_err_count >= threshold); // [R1]
            health[SLLS_BIT_INVALID_CODE] <= (invalid_code_count >= threshold); // [R2]
            health[SLLS_BIT_STRAY_K] <= (stray_control_char_count >= threshold); // [R3]
            health[SLLS_BIT_DESKEW] <= deskew_ok; // [R4]
            health[SLLS_BIT_INIT_ALIGN] <= init_align_ok; // [R5]
            health[SLLS_BIT_CONFIG_SUM] <= config_sum_ok; // [R6]
            health[SLLS_BIT_FRAME] <= frame_lock; // [R7]
            health[SLLS_BIT_CODEGROUP] <= codegroup_lock; // [R8]
        end
    end

endmodule : slls_lane_health

// *** verilog/slls_link_status.sv ***
// Top of the serial lane link status block: paged lane status over Avalon-MM

// Functional notes
// R1: Bit 7 set when disparity count reaches threshold
// R2: Bit 6 set when invalid code count reaches threshold
// R3: Bit 5 set when stray K count reaches threshold
// R4: Bit 4 shows interlane deskew achieved
// R5: Bit 3 shows initial lane alignment held
// R6: Bit 2 shows configuration checksum correct
// R7: Bit 1 shows frame lock held
// R8: Bit 0 shows code group lock held
// R9: Fields report the link chosen by page selector
// R10: Lane 2 at 0x4B2, lane 3 at 0x4B3, reset zero
// R11: Status writes ignored; reads return live status
module slls_link_status
    import slls_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [SLLS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [SLLS_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [SLLS_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic [SLLS_NUM_LINKS-1:0][7:0] lane2_disparity_err_count,
    input wire logic [SLLS_NUM_LINKS-1:0][7:0] lane2_invalid_code_count,
    input wire logic [SLLS_NUM_LINKS-1:0][7:0] lane2_stray_control_char_count,
    input wire logic [SLLS_NUM_LINKS-1:0] lane2_deskew_ok,
    input wire logic [SLLS_NUM_LINKS-1:0] lane2_init_align_ok,
    input wire logic [SLLS_NUM_LINKS-1:0] lane2_config_sum_ok,
    input wire logic [SLLS_NUM_LINKS-1:0] lane2_frame_lock,
    input wire logic [SLLS_NUM_LINKS-1:0] lane2_codegroup_lock,
    input wire logic [SLLS_NUM_LINKS-1:0][7:0] lane3_disparity_err_count,
    input wire logic [SLLS_NUM_LINKS-1:0][7:0] lane3_invalid_code_count,
    input wire logic [SLLS_NUM_LINKS-1:0][7:0] lane3_stray_control_char_count,
    input wire logic [SLLS_NUM_LINKS-1:0] lane3_deskew_ok,
    input wire logic [SLLS_NUM_LINKS-1:0] lane3_init_align_ok,
    input wire logic [SLLS_NUM_LINKS-1:0] lane3_config_sum_ok,
    input wire logic [SLLS_NUM_LINKS-1:0] lane3_frame_lock,
    input wire logic [SLLS_NUM_LINKS-1:0] lane3_codegroup_lock
);

    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************
    // Software-visible registers and bus state
    // ****************************************************
    logic [SLLS_SEL_W-1:0] link_select;
    logic [7:0] error_count_threshold;
    logic [7:0] lane2_link_health;
    logic [7:0] lane3_link_health;
    slls_bus_state_type bus_state;
    slls_bus_state_type next_bus_state;

    // Selected-link views of the lane inputs
    logic [7:0] l2_disp_sel;
    logic [7:0] l2_code_sel;
    logic [7:0] l2_kchr_sel;
    logic [4:0] l2_sync_sel;
    logic [7:0] l3_disp_sel;
    logic [7:0] l3_code_sel;
    logic [7:0] l3_kchr_sel;
    logic [4:0] l3_sync_sel;

    // Bus decode
    logic addr_aligned;
    logic hit_page;
    logic hit_threshold;
    logic hit_lane2;
    logic hit_lane3;
    logic hit_any;
    logic request;
    logic write_commit;
    logic [SLLS_DATA_W-1:0] next_readdata;

    // ****************************************************
    // Link page selection
    // ****************************************************
    // Sync bits packed {deskew, init_align, config_sum, frame, codegroup}
    always_comb begin
        l2_disp_sel = lane2_disparity_err_count[link_select]; // [R9]
        l2_code_sel = lane2_invalid_code_count[link_select];
        l2_kchr_sel = lane2_stray_control_char_count[link_select];
        l2_sync_sel = {lane2_deskew_ok[link_select], lane2_init_align_ok[link_select],
                       lane2_config_sum_ok[link_select], lane2_frame_lock[link_select],
                       lane2_codegroup_lock[link_select]};
        l3_disp_sel = lane3_disparity_err_count[link_select]; // [R9]
        l3_code_sel = lane3_invalid_code_count[link_select];
        l3_kchr_sel = lane3_stray_control_char_count[link_select];
        l3_sync_sel = {lane3_deskew_ok[link_select], lane3_init_align_ok[link_select],
                       lane3_config_sum_ok[link_select], lane3_frame_lock[link_select],
                       lane3_codegroup_lock[link_select]};
    end

    // ****************************************************
    // Per-lane status bytes
    // ****************************************************
    slls_lane_health u_lane2 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .threshold(error_count_threshold),
        .disparity_err_count(l2_disp_sel),
        .invalid_code_count(l2_code_sel),
        .stray_control_char_count(l2_kchr_sel),
        .deskew_ok(l2_sync_sel[4]),
        .init_align_ok(l2_sync_sel[3]),
        .config_sum_ok(l2_sync_sel[2]),
        .frame_lock(l2_sync_sel[1]),
        .codegroup_lock(l2_sync_sel[0]),
        .health(lane2_link_health)
    );

    slls_lane_health u_lane3 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .threshold(error_count_threshold),
        .disparity_err_count(l3_disp_sel),
        .invalid_code_count(l3_code_sel),
        .stray_control_char_count(l3_kchr_sel),
        .deskew_ok(l3_sync_sel[4]),
        .init_align_ok(l3_sync_sel[3]),
        .config_sum_ok(l3_sync_sel[2]),
        .frame_lock(l3_sync_sel[1]),
        .codegroup_lock(l3_sync_sel[0]),
        .health(lane3_link_health)
    );

    // ****************************************************
    // Avalon-MM slave
    // ****************************************************
    assign addr_aligned = (avs_address[1:0] == 2'h0);
    assign hit_page = addr_aligned && (avs_address == SLLS_ADDR_LINK_PAGE);
    assign hit_threshold = addr_aligned && (avs_address == SLLS_ADDR_THRESHOLD);
    assign hit_lane2 = addr_aligned && (avs_address == SLLS_ADDR_LANE2); // [R10]
    assign hit_lane3 = addr_aligned && (avs_address == SLLS_ADDR_LANE3); // [R10]
    assign hit_any = hit_page || hit_threshold || hit_lane2 || hit_lane3;
    assign request = avs_read || avs_write;
    // The master still holds the request during the ack cycle
    assign write_commit = (bus_state == SLLS_ACK) && avs_write;

    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            SLLS_IDLE: begin
                if (request) begin
                    next_bus_state = SLLS_ACK;
                end
            end
            SLLS_ACK: begin
                next_bus_state = SLLS_IDLE;
            end
            default: begin
                next_bus_state = SLLS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_state <= SLLS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // Waitrequest idles high; drops for exactly the one ack cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((bus_state == SLLS_IDLE) && request);
        end
    end

    // Status bytes are sampled at request time, so a read sees live state
    always_comb begin
        next_readdata = '0;
        if (hit_page) begin
            next_readdata[SLLS_SEL_W-1:0] = link_select;
        end else if (hit_threshold) begin
            next_readdata[7:0] = error_count_threshold;
        end else if (hit_lane2) begin
            next_readdata[7:0] = lane2_link_health; // [R11]
        end else if (hit_lane3) begin
            next_readdata[7:0] = lane3_link_health; // [R11]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
            avs_response <= SLLS_RESP_OKAY;
        end else if ((bus_state == SLLS_IDLE) && request) begin
            avs_readdata <= avs_read ? next_readdata : '0;
            avs_response <= hit_any ? SLLS_RESP_OKAY : SLLS_RESP_DECODEERROR;
        end
    end

    // Only the page and threshold bytes accept writes; status is read-only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            link_select <= SLLS_SEL_RESET;
        end else if (write_commit && hit_page && avs_byteenable[0]) begin
            link_select <= avs_writedata[SLLS_SEL_W-1:0]; // [R9]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            error_count_threshold <= SLLS_THRESHOLD_RESET;
        end else if (write_commit && hit_threshold && avs_byteenable[0]) begin
            error_count_threshold <= avs_writedata[7:0];
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_DISPARITY_FLAG: assert property ( // [R1]
        !$past(sys_rst) |-> lane2_link_health[SLLS_BIT_DISPARITY] == ($past(l2_disp_sel) >= $past(error_count_threshold)))
        else $error("lane 2 disparity flag disagrees with count and threshold");

    AST_INVALID_CODE_FLAG: assert property ( // [R2]
        !$past(sys_rst) |-> lane3_link_health[SLLS_BIT_INVALID_CODE] ==
            ($past(l3_code_sel) >= $past(error_count_threshold)))
        else $error("lane 3 invalid code flag disagrees with count and threshold");

    AST_STRAY_K_FLAG: assert property ( // [R3]
        !$past(sys_rst) && ($past(l2_kchr_sel) < $past(error_count_threshold))
            |-> !lane2_link_health[SLLS_BIT_STRAY_K])
        else $error("lane 2 stray K flag set below threshold");

    AST_DESKEW_BIT: assert property ( // [R4]
        !$past(sys_rst) |-> lane3_link_health[SLLS_BIT_DESKEW] == $past(l3_sync_sel[4]))
        else $error("lane 3 deskew bit does not follow selected link");

    AST_INIT_ALIGN_BIT: assert property ( // [R5]
        $fell(l2_sync_sel[3]) && !$past(sys_rst) |=> !lane2_link_health[SLLS_BIT_INIT_ALIGN])
        else $error("lane 2 alignment loss not reported next cycle");

    AST_CONFIG_SUM_BIT: assert property ( // [R6]
        !$past(sys_rst) |-> lane2_link_health[SLLS_BIT_CONFIG_SUM] == $past(l2_sync_sel[2]))
        else $error("lane 2 checksum bit does not follow selected link");

    AST_FRAME_BIT: assert property ( // [R7]
        !$past(sys_rst) |-> lane3_link_health[SLLS_BIT_FRAME] == $past(l3_sync_sel[1]))
        else $error("lane 3 frame lock bit does not follow selected link");

    AST_CODEGROUP_BIT: assert property ( // [R8]
        !$past(sys_rst) |-> lane2_link_health[SLLS_BIT_CODEGROUP] == $past(lane2_codegroup_lock[link_select]))
        else $error("lane 2 code group bit does not follow selected link");

    AST_PAGE_WRITE: assert property ( // [R9]
        write_commit && hit_page && avs_byteenable[0] |=> link_select == $past(avs_writedata[SLLS_SEL_W-1:0]))
        else $error("page selector did not take written value");

    AST_LANE_READ: assert property ( // [R10]
        (bus_state == SLLS_IDLE) && avs_read && hit_lane3
            |=> !avs_waitrequest && avs_readdata == {24'h0, $past(lane3_link_health)})
        else $error("lane 3 read returned wrong data");

    AST_STATUS_WRITE_IGNORED: assert property ( // [R11]
        write_commit && (hit_lane2 || hit_lane3) |=> $stable(link_select) && $stable(error_count_threshold))
        else $error("write to status byte changed control state");

    AST_ONE_CYCLE_ACK: assert property (
        (bus_state == SLLS_IDLE) && request |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");

    AST_HEALTH_RESET: assert property ( // [R10]
        $past(sys_rst) |-> lane2_link_health == SLLS_HEALTH_RESET && lane3_link_health == SLLS_HEALTH_RESET)
        else $error("status byte not cleared by reset");

    AST_BUS_RESET: assert property (
        $past(sys_rst) |-> avs_waitrequest && avs_readdata == '0 && avs_response == SLLS_RESP_OKAY)
        else $error("bus outputs not at reset values after reset");

    AST_UNMAPPED_RESP: assert property ( // [R10]
        (bus_state == SLLS_IDLE) && request && !hit_any
            |=> avs_response == SLLS_RESP_DECODEERROR && avs_readdata == '0)
        else $error("unmapped access not answered with decode error");

    // ****************************************************
    // Coverage
    // ****************************************************
    COV_LANE2_READ: cover property ((bus_state == SLLS_ACK) && avs_read && hit_lane2);
    COV_PAGE_SWITCH: cover property (write_commit && hit_page ##[1:20] (bus_state == SLLS_ACK) && avs_read && hit_lane3);
    COV_FLAG_SET: cover property ($rose(lane2_link_health[SLLS_BIT_DISPARITY]));
    COV_UNMAPPED: cover property (!avs_waitrequest && (avs_response == SLLS_RESP_DECODEERROR));

endmodule : slls_link_status

// *** tb/slls_lane_source.sv ***
// Far-side model: per-link lane status as the receive lanes report it
module slls_lane_source
    import slls_pkg::*;
(
    input wire logic ref_clk,
    input wire logic load,
    input wire logic [SLLS_SEL_W-1:0] link_idx,
    input wire logic lane_idx,
    input wire logic [7:0] set_disparity,
    input wire logic [7:0] set_invalid,
    input wire logic [7:0] set_stray,
    input wire logic [4:0] set_flags,
    output logic [SLLS_NUM_LINKS-1:0][7:0] lane2_disparity_err_count,
    output logic [SLLS_NUM_LINKS-1:0][7:0] lane2_invalid_code_count,
    output logic [SLLS_NUM_LINKS-1:0][7:0] lane2_stray_control_char_count,
    output logic [SLLS_NUM_LINKS-1:0] lane2_deskew_ok,
    output logic [SLLS_NUM_LINKS-1:0] lane2_init_align_ok,
    output logic [SLLS_NUM_LINKS-1:0] lane2_config_sum_ok,
    output logic [SLLS_NUM_LINKS-1:0] lane2_frame_lock,
    output logic [SLLS_NUM_LINKS-1:0] lane2_codegroup_lock,
    output logic [SLLS_NUM_LINKS-1:0][7:0] lane3_disparity_err_count,
    output logic [SLLS_NUM_LINKS-1:0][7:0] lane3_invalid_code_count,
    output logic [SLLS_NUM_LINKS-1:0][7:0] lane3_stray_control_char_count,
    output logic [SLLS_NUM_LINKS-1:0] lane3_deskew_ok,
    output logic [SLLS_NUM_LINKS-1:0] lane3_init_align_ok,
    output logic [SLLS_NUM_LINKS-1:0] lane3_config_sum_ok,
    output logic [SLLS_NUM_LINKS-1:0] lane3_frame_lock,
    output logic [SLLS_NUM_LINKS-1:0] lane3_codegroup_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    // Link starts unsynchronised with clean counters
    initial begin
        {lane2_disparity_err_count, lane2_invalid_code_count, lane2_stray_control_char_count, lane2_deskew_ok,
            lane2_init_align_ok, lane2_config_sum_ok, lane2_frame_lock, lane2_codegroup_lock} = '0;
        {lane3_disparity_err_count, lane3_invalid_code_count, lane3_stray_control_char_count, lane3_deskew_ok,
            lane3_init_align_ok, lane3_config_sum_ok, lane3_frame_lock, lane3_codegroup_lock} = '0;
    end

    // Status moves only on a clock edge, like the synchronous receive path
    always @(posedge ref_clk) begin
        if (load && !lane_idx) begin
            lane2_disparity_err_count[link_idx] <= set_disparity;
            lane2_invalid_code_count[link_idx] <= set_invalid;
            lane2_stray_control_char_count[link_idx] <= set_stray;
            {lane2_deskew_ok[link_idx], lane2_init_align_ok[link_idx], lane2_config_sum_ok[link_idx],
                lane2_frame_lock[link_idx], lane2_codegroup_lock[link_idx]} <= set_flags;
        end
        if (load && lane_idx) begin
            lane3_disparity_err_count[link_idx] <= set_disparity;
            lane3_invalid_code_count[link_idx] <= set_invalid;
            lane3_stray_control_char_count[link_idx] <= set_stray;
            {lane3_deskew_ok[link_idx], lane3_init_align_ok[link_idx], lane3_config_sum_ok[link_idx],
                lane3_frame_lock[link_idx], lane3_codegroup_lock[link_idx]} <= set_flags;
        end
    end
endmodule : slls_lane_source

// *** tb/test_slls_link_status.sv ***
// Self-checking bench for the serial lane link status block
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module test_slls_link_status
    import slls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [SLLS_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [SLLS_DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [SLLS_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic load = 1'b0;
    logic [SLLS_SEL_W-1:0] link_idx = '0;
    logic lane_idx = 1'b0;
    logic [7:0] set_disparity = 8'h00, set_invalid = 8'h00, set_stray = 8'h00;
    logic [4:0] set_flags = 5'h00;
    logic [SLLS_NUM_LINKS-1:0][7:0] lane2_disparity_err_count, lane2_invalid_code_count, lane2_stray_control_char_count;
    logic [SLLS_NUM_LINKS-1:0][7:0] lane3_disparity_err_count, lane3_invalid_code_count, lane3_stray_control_char_count;
    logic [SLLS_NUM_LINKS-1:0] lane2_deskew_ok, lane2_init_align_ok, lane2_config_sum_ok, lane2_frame_lock;
    logic [SLLS_NUM_LINKS-1:0] lane3_deskew_ok, lane3_init_align_ok, lane3_config_sum_ok, lane3_frame_lock;
    logic [SLLS_NUM_LINKS-1:0] lane2_codegroup_lock, lane3_codegroup_lock;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    slls_link_status dut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
        .lane2_disparity_err_count, .lane2_invalid_code_count, .lane2_stray_control_char_count,
        .lane2_deskew_ok, .lane2_init_align_ok, .lane2_config_sum_ok, .lane2_frame_lock, .lane2_codegroup_lock,
        .lane3_disparity_err_count, .lane3_invalid_code_count, .lane3_stray_control_char_count,
        .lane3_deskew_ok, .lane3_init_align_ok, .lane3_config_sum_ok, .lane3_frame_lock, .lane3_codegroup_lock);

    slls_lane_source far_end (.ref_clk, .load, .link_idx, .lane_idx, .set_disparity, .set_invalid, .set_stray,
        .set_flags, .lane2_disparity_err_count, .lane2_invalid_code_count, .lane2_stray_control_char_count,
        .lane2_deskew_ok, .lane2_init_align_ok, .lane2_config_sum_ok, .lane2_frame_lock, .lane2_codegroup_lock,
        .lane3_disparity_err_count, .lane3_invalid_code_count, .lane3_stray_control_char_count,
        .lane3_deskew_ok, .lane3_init_align_ok, .lane3_config_sum_ok, .lane3_frame_lock, .lane3_codegroup_lock);

    always #20 ref_clk = ~ref_clk;

    // ****************************************************
    // Bus and stimulus helpers
    // ****************************************************
    // Request is held until the edge that samples waitrequest low; the global timeout ends a hang
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] wd, input logic [3:0] be,
        output logic [31:0] rd, output logic [1:0] rs);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input string what, input logic [13:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bus(1'b0, a, 32'h0, 4'hf, d, r);
        `CHK(what, ({24'h0, exp}), d)
        `CHK(what, er, r)
    endtask : rd_chk

    task automatic wr(input logic [13:0] a, input logic [7:0] v, input logic [3:0] be);
        logic [31:0] d;
        logic [1:0] r;
        bus(1'b1, a, {24'h0, v}, be, d, r);
        `CHK("write resp", SLLS_RESP_OKAY, r)
    endtask : wr

    // Two spare edges let the status register stage catch up before the next read
    task automatic set_lane(input logic lk, input logic ln, input logic [7:0] d, i, s, input logic [4:0] f);
        @(posedge ref_clk);
        load <= 1'b1;
        link_idx <= lk;
        lane_idx <= ln;
        set_disparity <= d;
        set_invalid <= i;
        set_stray <= s;
        set_flags <= f;
        @(posedge ref_clk);
        load <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : set_lane

    function automatic logic [7:0] hb(input logic [7:0] d, i, s, thr, input logic [4:0] f);
        return {d >= thr, i >= thr, s >= thr, f};
    endfunction : hb

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_flags();
        for (int ln = 0; ln < 2; ln++) begin
            for (int b = 0; b < 5; b++) begin
                set_lane(1'b0, ln[0], 8'h00, 8'h00, 8'h00, 5'h01 << b);
                rd_chk("flag", ln ? SLLS_ADDR_LANE3 : SLLS_ADDR_LANE2, hb(8'h00, 8'h00, 8'h00, 8'hff, 5'h01 << b),
                    SLLS_RESP_OKAY);
            end
        end
    endtask : t_flags

    // Counts sit at the threshold or one either side of it, plus one stray count at 0xff
    task automatic t_thresh();
        wr(SLLS_ADDR_THRESHOLD, 8'h10, 4'h1);
        set_lane(1'b0, 1'b0, 8'h0f, 8'h10, 8'h11, 5'h00);
        rd_chk("lane2 thr", SLLS_ADDR_LANE2, hb(8'h0f, 8'h10, 8'h11, 8'h10, 5'h00), SLLS_RESP_OKAY);
        set_lane(1'b0, 1'b1, 8'h10, 8'h0f, 8'hff, 5'h11);
        rd_chk("lane3 thr", SLLS_ADDR_LANE3, hb(8'h10, 8'h0f, 8'hff, 8'h10, 5'h11), SLLS_RESP_OKAY);
        wr(SLLS_ADDR_THRESHOLD, 8'h00, 4'h0);
        rd_chk("lane3 thr kept", SLLS_ADDR_LANE3, hb(8'h10, 8'h0f, 8'hff, 8'h10, 5'h11), SLLS_RESP_OKAY);
    endtask : t_thresh

    task automatic t_page();
        set_lane(1'b1, 1'b0, 8'hff, 8'h00, 8'h0f, 5'h1f);
        set_lane(1'b1, 1'b1, 8'h00, 8'h20, 8'h00, 5'h0a);
        rd_chk("page0 lane2", SLLS_ADDR_LANE2, hb(8'h0f, 8'h10, 8'h11, 8'h10, 5'h00), SLLS_RESP_OKAY);
        wr(SLLS_ADDR_LINK_PAGE, 8'h01, 4'h1);
        rd_chk("page1 lane2", SLLS_ADDR_LANE2, hb(8'hff, 8'h00, 8'h0f, 8'h10, 5'h1f), SLLS_RESP_OKAY);
        rd_chk("page1 lane3", SLLS_ADDR_LANE3, hb(8'h00, 8'h20, 8'h00, 8'h10, 5'h0a), SLLS_RESP_OKAY);
        wr(SLLS_ADDR_LINK_PAGE, 8'h00, 4'h1);
        rd_chk("page0 lane3", SLLS_ADDR_LANE3, hb(8'h10, 8'h0f, 8'hff, 8'h10, 5'h11), SLLS_RESP_OKAY);
    endtask : t_page

    task automatic t_access();
        wr(SLLS_ADDR_LANE2, 8'hff, 4'hf);
        rd_chk("lane2 after write", SLLS_ADDR_LANE2, hb(8'h0f, 8'h10, 8'h11, 8'h10, 5'h00), SLLS_RESP_OKAY);
        set_lane(1'b0, 1'b0, 8'h20, 8'h00, 8'h00, 5'h1f);
        rd_chk("lane2 live", SLLS_ADDR_LANE2, hb(8'h20, 8'h00, 8'h00, 8'h10, 5'h1f), SLLS_RESP_OKAY);
        rd_chk("unmapped", 14'h0004, 8'h00, SLLS_RESP_DECODEERROR);
        rd_chk("misaligned", SLLS_ADDR_LANE2 | 14'h0001, 8'h00, SLLS_RESP_DECODEERROR);
    endtask : t_access

    // Mid-run reset: selector and threshold return to defaults while the far side keeps its status
    task automatic t_reset();
        wr(SLLS_ADDR_LINK_PAGE, 8'h01, 4'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("rst wait", 1'b1, avs_waitrequest)
        `CHK("rst data", 32'h0, avs_readdata)
        sys_rst <= 1'b0;
        rd_chk("rst page", SLLS_ADDR_LINK_PAGE, 8'h00, SLLS_RESP_OKAY);
        rd_chk("rst thr", SLLS_ADDR_THRESHOLD, 8'hff, SLLS_RESP_OKAY);
        rd_chk("rst lane2", SLLS_ADDR_LANE2, hb(8'h20, 8'h00, 8'h00, 8'hff, 5'h1f), SLLS_RESP_OKAY);
    endtask : t_reset

    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Whole run needs under two hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk("lane2 reset", SLLS_ADDR_LANE2, 8'h00, SLLS_RESP_OKAY);
        rd_chk("lane3 reset", SLLS_ADDR_LANE3, 8'h00, SLLS_RESP_OKAY);
        t_flags();
        t_thresh();
        t_page();
        t_access();
        t_reset();
        end_of_test();
    end
endmodule : test_slls_link_status
